/* File: rtl/lmpsc_pkg.sv */
// Function
// - PWM is the only drive mode
// - 8-bit duty register gives 256 steps
// - New duty values reach the LED output
// - Selectable row pull-downs and column pull-ups
// - Pulls engage only while output is off
// - Shutdown never clears stored registers
// - Soft shutdown bit low blanks matrix
// - Register access unchanged in soft shutdown
// - Shutdown pin low disables outputs
// - Register access kept in hardware shutdown
package lmpsc_pkg;
  localparam int ROWS = 9;
  localparam int COLS = 39;
  localparam int LEDS = ROWS * COLS;
  localparam int DUTY_W = 8;
  localparam int LED_AW = 9;
  localparam int PULL_W = 3;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 8'h00;
  localparam logic [DUTY_W-1:0] DUTY_LAST = 8'hff;
  localparam logic [PULL_W-1:0] PULL_RESET = 3'h0;
  localparam logic [3:0] ROW_LAST = 4'h8;
  localparam logic [LED_AW-1:0] LED_AW_ONE = 9'h001;
  localparam logic [3:0] ROW_ONE = 4'h1;
  localparam logic [LED_AW-1:0] COLS_W = 9'h027;
endpackage : lmpsc_pkg

/* File: rtl/lmpsc_duty_cmp.sv */
`timescale 1ns/1ns
`default_nettype none
// Per-LED duty comparator for the active row
module lmpsc_duty_cmp
  import lmpsc_pkg::*;
(
  // Phase and duty
  input wire logic [lmpsc_pkg::DUTY_W-1:0] phase,
  input wire logic [lmpsc_pkg::DUTY_W-1:0] duty,
  // Result
  output logic on
);
  // Duty 0 never lights; duty N lights N of 256 phases
  assign on = (phase < duty);
endmodule : lmpsc_duty_cmp
`default_nettype wire

/* File: rtl/lmpsc_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module lmpsc_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Duty register write port
  input wire logic duty_we,
  input wire logic [lmpsc_pkg::LED_AW-1:0] duty_addr,
  input wire logic [lmpsc_pkg::DUTY_W-1:0] duty_wdata,
  // Duty register read port
  input wire logic [lmpsc_pkg::LED_AW-1:0] duty_raddr,
  output logic [lmpsc_pkg::DUTY_W-1:0] duty_rdata,
  // Configuration writes
  input wire logic cfg_we,
  input wire logic soft_shutdown_n_wdata,
  input wire logic pull_we,
  input wire logic [lmpsc_pkg::PULL_W-1:0] row_pull_wdata,
  input wire logic [lmpsc_pkg::PULL_W-1:0] col_pull_wdata,
  // Shutdown pin, asynchronous
  input wire logic hw_shutdown_n_pin,
  // Configuration readback
  output logic soft_shutdown_n,
  output logic [lmpsc_pkg::PULL_W-1:0] row_pull_sel,
  output logic [lmpsc_pkg::PULL_W-1:0] col_pull_sel,
  // Status
  output logic hw_shutdown_active,
  output logic outputs_enabled,
  // Matrix drive
  output logic [lmpsc_pkg::ROWS-1:0] row_switch_out,
  output logic [lmpsc_pkg::COLS-1:0] column_sink_out,
  output logic [lmpsc_pkg::ROWS-1:0] row_pull_en,
  output logic [lmpsc_pkg::COLS-1:0] col_pull_en
);
  import lmpsc_pkg::*;

  logic [DUTY_W-1:0] duty_mem [LEDS];
  logic sdb_meta;
  logic sdb_sync;
  logic [DUTY_W-1:0] phase;
  logic [3:0] row;
  logic [LED_AW-1:0] row_base;
  logic [COLS-1:0] col_on;
  logic [COLS-1:0] next_col;
  logic [ROWS-1:0] next_row;
  logic run;

  // Duty store: no shutdown term, so contents survive both shutdowns
  always_ff @(posedge mclk) begin
    if (duty_we) begin
      duty_mem[duty_addr] <= duty_wdata;
    end
  end

  // Readback served whenever reset is low, independent of shutdown state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      duty_rdata <= DUTY_RESET;
    end else begin
      duty_rdata <= duty_mem[duty_raddr];
    end
  end

  // Configuration; only reset clears it, never a shutdown
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      soft_shutdown_n <= 1'b0;
      row_pull_sel <= PULL_RESET;
      col_pull_sel <= PULL_RESET;
    end else begin
      if (cfg_we) begin
        soft_shutdown_n <= soft_shutdown_n_wdata;
      end
      if (pull_we) begin
        row_pull_sel <= row_pull_wdata;
        col_pull_sel <= col_pull_wdata;
      end
    end
  end

  // Two-flop synchroniser for the shutdown pin; reset assumes shutdown
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sdb_meta <= 1'b0;
      sdb_sync <= 1'b0;
    end else begin
      sdb_meta <= hw_shutdown_n_pin;
      sdb_sync <= sdb_meta;
    end
  end

  // Level sensitive: pin low holds shutdown, high releases it
  assign run = sdb_sync & soft_shutdown_n;

  // Status flops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hw_shutdown_active <= 1'b1;
      outputs_enabled <= 1'b0;
    end else begin
      hw_shutdown_active <= ~sdb_sync;
      outputs_enabled <= run;
    end
  end

  // PWM phase and row scan; the only drive mode there is
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase <= DUTY_RESET;
      row <= '0;
      row_base <= '0;
    end else begin
      phase <= phase + DUTY_W'(1);
      if (phase == DUTY_LAST) begin
        if (row == ROW_LAST) begin
          row <= '0;
          row_base <= '0;
        end else begin
          row <= row + ROW_ONE;
          row_base <= row_base + COLS_W;
        end
      end
    end
  end

  // One comparator per column of the active row
  genvar gc;
  generate
    for (gc = 0; gc < COLS; gc++) begin : g_col
      lmpsc_duty_cmp u_cmp (
        .phase(phase),
        .duty(duty_mem[row_base + LED_AW'(gc)]),
        .on(col_on[gc])
      );
    end
  endgenerate

  // Next drive: blanked whenever either shutdown holds
  always_comb begin
    next_row = '0;
    next_col = '0;
    if (run) begin
      next_row[row] = 1'b1;
      next_col = col_on;
    end
  end

  // Registered drive; pulls only on outputs that are off
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      row_switch_out <= '0;
      column_sink_out <= '0;
      row_pull_en <= '0;
      col_pull_en <= '0;
    end else begin
      row_switch_out <= next_row;
      column_sink_out <= next_col;
      row_pull_en <= ~next_row & {ROWS{row_pull_sel != PULL_RESET}};
      col_pull_en <= ~next_col & {COLS{col_pull_sel != PULL_RESET}};
    end
  end
endmodule : lmpsc_ctrl
`default_nettype wire

/* File: tb/lmpsc_chk_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module lmpsc_chk (
  // Watched ports
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cfg_we,
  input wire logic soft_shutdown_n_wdata,
  input wire logic soft_shutdown_n,
  input wire logic [8:0] row_switch_out,
  input wire logic [8:0] row_pull_en,
  input wire logic hw_shutdown_active,
  input wire logic outputs_enabled,
  input wire logic [38:0] column_sink_out,
  input wire logic [38:0] col_pull_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Three cycles let the drive pipeline drain
  property p_cfg; cfg_we |=> soft_shutdown_n == $past(soft_shutdown_n_wdata); endproperty
  a_cfg: assert property (p_cfg) else $error("cfg");
  sequence s_soft_held; !soft_shutdown_n [*3]; endsequence
  property p_soft; s_soft_held |-> row_switch_out == 9'h000; endproperty
  a_soft: assert property (p_soft) else $error("soft");
  property p_off; (row_pull_en & row_switch_out) == 9'h000; endproperty
  a_off: assert property (p_off) else $error("off");
  // Column pulls must never fight a conducting sink
  property p_colpull; (col_pull_en & column_sink_out) == 39'h0; endproperty
  a_colpull: assert property (p_colpull) else $error("colpull");
  // Without a write the soft bit holds
  property p_keep; !cfg_we |=> $stable(soft_shutdown_n); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_pin; hw_shutdown_active |-> (row_switch_out == 9'h000 && column_sink_out == 39'h0);
  endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_run; outputs_enabled |-> $onehot(row_switch_out); endproperty
  a_run: assert property (p_run) else $error("run");
endmodule : lmpsc_chk
bind lmpsc_ctrl lmpsc_chk chk_u (.*);
`default_nettype wire

/* File: tb/lmpsc_host.sv */
`timescale 1ns/1ns
`default_nettype none
module lmpsc_host (
  // Clock
  input wire logic mclk,
  // Write strobes and data
  output var logic duty_we,
  output var logic [8:0] duty_addr,
  output var logic [7:0] duty_wdata,
  output var logic cfg_we,
  output var logic soft_shutdown_n_wdata,
  output var logic pull_we,
  output var logic [2:0] row_pull_wdata,
  output var logic [2:0] col_pull_wdata
);
  // Idle from time zero
  initial {duty_we, duty_addr, duty_wdata, cfg_we, soft_shutdown_n_wdata, pull_we,
    row_pull_wdata, col_pull_wdata} = '0;
  // One cycle strobes all three writes together
  task put(input logic [8:0] a, input logic [7:0] d, input logic [6:0] c);
    @(posedge mclk);
    {duty_we, duty_addr, duty_wdata} <= {1'b1, a, d};
    {cfg_we, pull_we, soft_shutdown_n_wdata, row_pull_wdata, col_pull_wdata} <= {2'h3, c};
    @(posedge mclk);
    {duty_we, cfg_we, pull_we} <= 3'h0;
  endtask : put
endmodule : lmpsc_host
`default_nettype wire

/* File: tb/led_matrix_pwm_shutdown_ctrl_test.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module led_matrix_pwm_shutdown_ctrl_test;
  logic mclk, sys_rst, hw_shutdown_n_pin, duty_we, cfg_we, pull_we, soft_shutdown_n_wdata;
  logic soft_shutdown_n, hw_shutdown_active, outputs_enabled;
  logic [8:0] duty_addr, duty_raddr, row_switch_out, row_pull_en;
  logic [7:0] duty_wdata, duty_rdata;
  logic [2:0] row_pull_wdata, col_pull_wdata, row_pull_sel, col_pull_sel;
  logic [38:0] column_sink_out, col_pull_en;
  int error_cnt = 0, compares = 0, n;
  lmpsc_ctrl dut_u (.*);
  lmpsc_host host_u (.*);
  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task complete_run;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // Bounded wait, then lit cycles of LED 0 over a whole frame
  task frame(input int e);
    repeat (20) if (outputs_enabled !== 1'b1) @(posedge mclk);
    `CHK("enabled", 1'b1, outputs_enabled)
    repeat (4) @(posedge mclk);
    n = 0;
    repeat (2304) @(posedge mclk) n += int'(row_switch_out[0] & column_sink_out[0]);
    `CHK("lit", e, n)
  endtask : frame
  initial begin
    {sys_rst, hw_shutdown_n_pin, duty_raddr} = {2'h3, 9'h000};
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    `CHK("cfg_rst", 7'h00, {soft_shutdown_n, row_pull_sel, col_pull_sel})
    // Duty store has no reset; clear every LED so no column floats unknown
    for (int i = 0; i < 351; i++) host_u.put(9'(i), 8'h00, 7'h00);
    host_u.put(9'h000, 8'h04, 7'h4a);
    frame(4);
    $display("test pwm done");
    `CHK("cfg", 7'h4a, {soft_shutdown_n, row_pull_sel, col_pull_sel})
    hw_shutdown_n_pin <= 1'b0;
    host_u.put(9'h000, 8'h10, 7'h4a);
    repeat (4) @(posedge mclk);
    `CHK("hw", {1'b1, 48'h0}, {hw_shutdown_active, row_switch_out, column_sink_out})
    hw_shutdown_n_pin <= 1'b1;
    frame(16);
    $display("test hw done");
    host_u.put(9'h000, 8'h10, 7'h0a);
    host_u.put(9'h000, 8'h20, 7'h0a);
    `CHK("blank", 48'h0, {row_switch_out, column_sink_out})
    `CHK("pulls", {9'h1ff, 39'h7fffffffff}, {row_pull_en, col_pull_en})
    // Readback lags one edge; sample mid-cycle where it is settled
    repeat (2) @(negedge mclk);
    `CHK("rdata", 8'h20, duty_rdata)
    host_u.put(9'h001, 8'h00, 7'h4a);
    frame(32);
    $display("test sw done");
    complete_run();
  end
endmodule : led_matrix_pwm_shutdown_ctrl_test
`default_nettype wire
